// *** hdl/pci_sec_support.sv ***
// secondary-bus support: clock outputs, arbiter, config translation, messages
// assumes all inputs synchronous to ref_clk; config registers reached by byte port
`timescale 1ns/1ps
module pci_sec_support #(
    parameter int PME_RESEND_CYC = pci_sec_pkg::PME_RESEND_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        base_frequency_select,
    input  wire logic        m66en,
    output logic [6:0]       secondary_clock_outputs,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    input  wire logic [5:0]  req_n,
    input  wire logic        bridge_req,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    output logic [5:0]       gnt_n,
    output logic             bridge_gnt,
    input  wire logic        cfg_req,
    input  wire logic        cfg_type1,
    input  wire logic [7:0]  cfg_bus,
    input  wire logic [4:0]  cfg_dev,
    input  wire logic [2:0]  cfg_fn,
    input  wire logic [5:0]  cfg_reg,
    input  wire logic [7:0]  sec_bus_num,
    output logic             cfg_local,
    output logic             pci_cfg_valid,
    output logic             pci_cfg_type1,
    output logic [31:0]      pci_cfg_addr,
    input  wire logic [3:0]  intx_n,
    input  wire logic        pme_n,
    input  wire logic        msg_ready,
    output logic             msg_valid,
    output pci_sec_pkg::msg_kind_t msg_kind,
    output logic [1:0]       msg_code,
    output logic [15:0]      msg_req_id,
    output logic [7:0]       msg_tag
);
    logic [7:0]              clk_en;
    logic [7:0]              arb_ctrl;
    logic [7:0]              req_mask;
    logic [5:0]              tmo_stat;
    logic [5:0]              auto_mask;
    logic [3:0]              div_cnt;
    logic [3:0]              next_cnt;
    logic [3:0]              per_cyc;
    logic                    div_wrap;
    logic                    next_phase;
    pci_sec_pkg::arb_state_t arb_state;
    pci_sec_pkg::arb_state_t next_state;
    logic [6:0]              gnt;
    logic [6:0]              next_gnt;
    logic [4:0]              tmo_cnt;
    logic [6:0]              active;
    logic [6:0]              high;
    logic [6:0]              pool;
    logic [6:0]              winner;
    logic                    bus_idle;
    logic                    tmo_hit;
    logic                    tmo_act;
    logic                    req_gone;
    logic [15:0]             idsel;
    logic                    to_secondary;
    logic [3:0]              intx_rep;
    logic [3:0]              intx_diff;
    logic                    pme_prev;
    logic                    pme_pend;
    logic [31:0]             pme_cnt;
    logic                    pme_fall;
    logic                    pme_tick;
    logic                    out_free;
    logic                    wr_clk;
    logic                    wr_ctrl;
    logic                    wr_mask;

    // frequency selection from the two straps
    // fast base pair
    assign per_cyc    = base_frequency_select ? (m66en ? pci_sec_pkg::PER66_CYC : pci_sec_pkg::PER33_CYC)
                                              : (m66en ? pci_sec_pkg::PER50_CYC : pci_sec_pkg::PER25_CYC);
    assign div_wrap   = (div_cnt >= per_cyc - 4'h1);
    assign next_cnt   = div_wrap ? 4'h0 : div_cnt + 4'h1;
    // high for the first half period; an odd period spends its extra cycle low
    assign next_phase = (next_cnt < {1'b0, per_cyc[3:1]});

    // divider: rates are rounded to whole reference periods, so 66 and 50 MHz share one rate
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            div_cnt <= 4'h0;
        else
            div_cnt <= next_cnt;
    end

    // gated clock outputs, bit 6 is the loopback output
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            secondary_clock_outputs <= 7'h00;
        else
            secondary_clock_outputs <= {7{next_phase}} & clk_en[6:0];
    end

    // register write decode
    assign wr_clk  = reg_wr && (reg_addr == pci_sec_pkg::CLK_EN_OFS);
    assign wr_ctrl = reg_wr && (reg_addr == pci_sec_pkg::ARB_CTRL_OFS);
    assign wr_mask = reg_wr && (reg_addr == pci_sec_pkg::REQ_MASK_OFS);

    // software owns the clock enables; unused bit 7 stays zero
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clk_en   <= pci_sec_pkg::CLK_EN_RST;
            arb_ctrl <= pci_sec_pkg::ARB_CTRL_RST;
            req_mask <= pci_sec_pkg::REQ_MASK_RST;
        end
        else
        begin
            if (wr_clk)
                clk_en <= {1'b0, reg_wdata[6:0]};
            if (wr_ctrl)
                arb_ctrl <= reg_wdata;
            if (wr_mask)
                req_mask <= reg_wdata;
        end
    end

    // read mux, unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            case (reg_addr)
                pci_sec_pkg::CLK_EN_OFS:   reg_rdata <= clk_en;
                pci_sec_pkg::ARB_CTRL_OFS: reg_rdata <= arb_ctrl;
                pci_sec_pkg::REQ_MASK_OFS: reg_rdata <= req_mask;
                pci_sec_pkg::TMO_STAT_OFS: reg_rdata <= {2'b00, tmo_stat};
                default:                   reg_rdata <= 8'h00;
            endcase
    end

    // high tier bits are 5:0 per device and 6 for the bridge
    assign active   = {bridge_req, ~req_n & ~req_mask[5:0] & ~auto_mask};
    assign high     = active & arb_ctrl[6:0];
    assign pool     = (|high) ? high : active;
    assign bus_idle = frame_n && irdy_n;
    assign req_gone = ~|(gnt & active);
    assign tmo_hit  = (tmo_cnt == pci_sec_pkg::TMO_CLKS - 5'h01);
    assign tmo_act  = tmo_hit && !gnt[6] && (req_mask[pci_sec_pkg::TMO_EN_BIT] || req_mask[pci_sec_pkg::AUTO_MASK_BIT]);

    // fixed order inside a tier: bridge first, then device 0 upward
    always_comb
    begin
        winner = 7'h00;
        if (pool[6])
            winner = 7'h40;
        else
            for (int i = 5; i >= 0; i--)
                if (pool[i])
                    winner = 7'(1 << i);
    end

    // arbiter sequencing; grants are only issued while the bus is idle
    always_comb
    begin
        next_state = arb_state;
        next_gnt   = gnt;
        case (arb_state)
            pci_sec_pkg::ARB_IDLE:
            begin
                // park on the bridge only when the park bit is set
                next_gnt = (|winner) ? winner : {arb_ctrl[pci_sec_pkg::PARK_BIT], 6'h00};
                if (|winner && bus_idle)
                    next_state = pci_sec_pkg::ARB_GRANTED;
                else if (!bus_idle)
                    next_gnt = 7'h00;
            end
            pci_sec_pkg::ARB_GRANTED:
            begin
                // the wait ends when the grantee opens a frame
                if (!frame_n)
                    next_state = pci_sec_pkg::ARB_BUSY;
                else if (req_gone || tmo_act)
                begin
                    next_state = pci_sec_pkg::ARB_IDLE;
                    next_gnt   = 7'h00;
                end
            end
            pci_sec_pkg::ARB_BUSY:
            begin
                next_gnt = 7'h00;
                if (bus_idle)
                    next_state = pci_sec_pkg::ARB_IDLE;
            end
            default:
            begin
                next_state = pci_sec_pkg::ARB_IDLE;
                next_gnt   = 7'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            arb_state  <= pci_sec_pkg::ARB_IDLE;
            gnt        <= 7'h00;
            gnt_n      <= 6'h3F;
            bridge_gnt <= 1'b0;
        end
        else
        begin
            arb_state  <= next_state;
            gnt        <= next_gnt;
            gnt_n      <= ~next_gnt[5:0];
            bridge_gnt <= next_gnt[6];
        end
    end

    // response counter runs only while waiting on a grantee
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            tmo_cnt <= 5'h00;
        else if (arb_state == pci_sec_pkg::ARB_GRANTED && frame_n && !tmo_hit)
            tmo_cnt <= tmo_cnt + 5'h01;
        else
            tmo_cnt <= 5'h00;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tmo_stat  <= 6'h00;
            auto_mask <= 6'h00;
        end
        else
        begin
            if (!req_mask[pci_sec_pkg::TMO_EN_BIT])
                tmo_stat <= 6'h00;
            else if (tmo_act && frame_n && arb_state == pci_sec_pkg::ARB_GRANTED)
                tmo_stat <= tmo_stat | gnt[5:0];
            if (!req_mask[pci_sec_pkg::AUTO_MASK_BIT])
                auto_mask <= 6'h00;
            else if (tmo_act && frame_n && arb_state == pci_sec_pkg::ARB_GRANTED)
                auto_mask <= auto_mask | gnt[5:0];
        end
    end

    assign to_secondary = cfg_type1 && (cfg_bus == sec_bus_num);
    assign idsel        = cfg_dev[4] ? 16'h0000 : 16'(16'h0001 << cfg_dev[3:0]);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_local     <= 1'b0;
            pci_cfg_valid <= 1'b0;
            pci_cfg_type1 <= 1'b0;
            pci_cfg_addr  <= 32'h0000_0000;
        end
        else
        begin
            // type 0 stays inside the bridge
            cfg_local     <= cfg_req && !cfg_type1;
            pci_cfg_valid <= cfg_req && cfg_type1;
            pci_cfg_type1 <= cfg_req && cfg_type1 && !to_secondary;
            if (cfg_req && cfg_type1)
                pci_cfg_addr <= to_secondary ? {idsel, 5'h00, cfg_fn, cfg_reg, 2'b00}
                                             : {8'h00, cfg_bus, cfg_dev, cfg_fn, cfg_reg, 2'b01};
        end
    end

    // pending interrupt changes are differences from what was reported
    assign intx_diff = intx_n ^ intx_rep;
    assign out_free  = !msg_valid || msg_ready;
    assign pme_fall  = pme_prev && !pme_n;
    assign pme_tick  = !pme_n && (pme_cnt == 32'(PME_RESEND_CYC - 1));

    // resend timer restarts on every fall and stops once released
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pme_prev <= 1'b1;
            pme_cnt  <= 32'h0000_0000;
        end
        else
        begin
            pme_prev <= pme_n;
            pme_cnt  <= (pme_n || pme_fall || pme_tick) ? 32'h0000_0000 : pme_cnt + 32'h0000_0001;
        end
    end

    // message output; interrupts beat power events, lowest line first
    // a new request landing on the send cycle survives: the set wins
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            intx_rep   <= pci_sec_pkg::INTX_IDLE;
            pme_pend   <= 1'b0;
            msg_valid  <= 1'b0;
            msg_kind   <= pci_sec_pkg::MSG_NONE;
            msg_code   <= 2'b00;
            msg_req_id <= 16'h0000;
            msg_tag    <= 8'h00;
        end
        else if (out_free)
        begin
            msg_valid <= 1'b0;
            msg_kind  <= pci_sec_pkg::MSG_NONE;
            pme_pend  <= pme_pend || pme_fall || pme_tick;
            if (|intx_diff)
            begin
                msg_valid <= 1'b1;
                for (int i = 3; i >= 0; i--)
                    if (intx_diff[i])
                    begin
                        msg_code <= 2'(i);
                        msg_kind <= intx_n[i] ? pci_sec_pkg::MSG_DEASSERT : pci_sec_pkg::MSG_ASSERT;
                    end
                intx_rep <= intx_rep ^ (intx_diff & (~intx_diff + 4'h1));
            end
            else if (pme_pend || pme_fall)
            begin
                // tag and requester of the power-event message
                msg_valid  <= 1'b1;
                msg_kind   <= pci_sec_pkg::MSG_PME;
                msg_code   <= 2'b00;
                msg_req_id <= {sec_bus_num, 8'h00};
                msg_tag    <= pci_sec_pkg::PME_TAG;
                pme_pend   <= pme_tick;
            end
        end
        else
            pme_pend <= pme_pend || pme_fall || pme_tick;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_granted_wait;
        arb_state == pci_sec_pkg::ARB_GRANTED && frame_n && !gnt[6] && !req_gone
            && req_mask[pci_sec_pkg::TMO_EN_BIT];
    endsequence

    a_clock_gating: assert property (!clk_en[0] |=> !secondary_clock_outputs[0])
        else $error("disabled clock output toggled");
    a_grant_onehot: assert property ($onehot0({bridge_gnt, ~gnt_n}))
        else $error("more than one grant active");
    a_masked_no_grant: assert property (arb_state == pci_sec_pkg::ARB_IDLE && req_mask[2] && !bridge_req
        && bus_idle |=> gnt_n[2])
        else $error("masked requester granted");
    a_timeout_flag: assert property (arb_state == pci_sec_pkg::ARB_IDLE ##1 s_granted_wait[*8] ##1
        s_granted_wait[*8]
        |=> (tmo_stat & $past(gnt[5:0])) != 6'h00 && arb_state == pci_sec_pkg::ARB_IDLE)
        else $error("silent grantee not flagged");
    a_type0_local: assert property (cfg_req && !cfg_type1 |=> cfg_local && !pci_cfg_valid)
        else $error("type 0 request forwarded");
    a_idsel_onehot: assert property (cfg_req && cfg_type1 && cfg_bus == sec_bus_num && !cfg_dev[4]
        |=> $onehot(pci_cfg_addr[31:16]) && pci_cfg_addr[1:0] == 2'b00)
        else $error("type 0 select not one-hot");
    a_type1_format: assert property (cfg_req && cfg_type1 && cfg_bus != sec_bus_num
        |=> pci_cfg_type1 && pci_cfg_addr[1:0] == 2'b01 && pci_cfg_addr[23:16] == $past(cfg_bus))
        else $error("type 1 address phase malformed");
    a_pme_fields: assert property (msg_valid && msg_kind == pci_sec_pkg::MSG_PME
        |-> msg_tag == 8'h00 && msg_req_id == {sec_bus_num, 8'h00})
        else $error("power-event message fields wrong");
    a_pme_sent: assert property (pme_fall && intx_diff == 4'h0 && out_free |=> msg_valid
        && msg_kind == pci_sec_pkg::MSG_PME)
        else $error("power-event message not sent");
endmodule

// *** hdl/pci_sec_pkg.sv ***
// constants, register map and types for the secondary-bus support block
// assumes a single 100 MHz reference clock; all users write pci_sec_pkg::name
package pci_sec_pkg;
    // register byte offsets in configuration space
    localparam logic [7:0] CLK_EN_OFS    = 8'hD8;
    localparam logic [7:0] ARB_CTRL_OFS  = 8'hDC;
    localparam logic [7:0] REQ_MASK_OFS  = 8'hDD;
    localparam logic [7:0] TMO_STAT_OFS  = 8'hDE;
    // reset values: all clocks on, bridge in the high tier
    localparam logic [7:0] CLK_EN_RST    = 8'h7F;
    localparam logic [7:0] ARB_CTRL_RST  = 8'h40;
    localparam logic [7:0] REQ_MASK_RST  = 8'h00;
    // field positions
    localparam int PARK_BIT        = 7;
    localparam int BRIDGE_TIER_BIT = 6;
    localparam int TMO_EN_BIT      = 7;
    localparam int AUTO_MASK_BIT   = 6;
    // clocking
    localparam int REF_MHZ  = 100;
    localparam int F66_MHZ  = 66;
    localparam int F33_MHZ  = 33;
    localparam int F50_MHZ  = 50;
    localparam int F25_MHZ  = 25;
    // reference cycles per output period, rounded to nearest, so 66 and 50 MHz both come out at 2 cycles
    localparam int PER66_RAW = (REF_MHZ + F66_MHZ / 2) / F66_MHZ;
    localparam int PER33_RAW = (REF_MHZ + F33_MHZ / 2) / F33_MHZ;
    localparam int PER50_RAW = (REF_MHZ + F50_MHZ / 2) / F50_MHZ;
    localparam int PER25_RAW = (REF_MHZ + F25_MHZ / 2) / F25_MHZ;
    localparam logic [3:0] PER66_CYC = 4'((PER66_RAW < 2) ? 2 : PER66_RAW);
    localparam logic [3:0] PER33_CYC = 4'((PER33_RAW < 2) ? 2 : PER33_RAW);
    localparam logic [3:0] PER50_CYC = 4'((PER50_RAW < 2) ? 2 : PER50_RAW);
    localparam logic [3:0] PER25_CYC = 4'((PER25_RAW < 2) ? 2 : PER25_RAW);
    // grant response window in reference clocks
    localparam logic [4:0] TMO_CLKS = 5'h10;
    // power-event resend interval
    localparam int PME_RESEND_US  = 1000;
    localparam int PME_RESEND_CYC = PME_RESEND_US * REF_MHZ;
    localparam logic [3:0] INTX_IDLE = 4'hF;
    localparam logic [7:0] PME_TAG   = 8'h00;
    typedef enum logic [1:0] {
        MSG_NONE     = 2'b00,
        MSG_ASSERT   = 2'b01,
        MSG_DEASSERT = 2'b10,
        MSG_PME      = 2'b11
    } msg_kind_t;
    typedef enum logic [1:0] {
        ARB_IDLE    = 2'b00,
        ARB_GRANTED = 2'b01,
        ARB_BUSY    = 2'b10
    } arb_state_t;
endpackage

// *** verif/pci_dev_model.sv ***
// behavioural devices on the secondary bus: requests, and a short transfer after grant
// assumes ref_clk timing; released frame_n and irdy_n sit at their pull-up level
`timescale 1ns/1ps
module pci_dev_model (
    input  wire logic       ref_clk,
    input  wire logic [5:0] want,
    input  wire logic [5:0] respond,
    input  wire logic [5:0] gnt_n,
    output logic [5:0]      req_n,
    output logic            frame_n,
    output logic            irdy_n
);
    logic [2:0] busy = 3'h0;
    assign req_n = ~want;
    // a silent device never starts, so the arbiter must give up on it
    always @(posedge ref_clk)
    begin
        if (busy != 3'h0)
            busy <= busy - 3'h1;
        else if ((~gnt_n & respond) != 6'h00)
            busy <= 3'h4;
    end
    // frame start marks the granted device as responding
    assign frame_n = !(busy > 3'h2);
    assign irdy_n  = !(busy != 3'h0 && busy < 3'h4);
endmodule

// *** verif/tb.sv ***
// self-checking bench: registers, clocks, arbiter, config translation, messages
// assumes the device model in pci_dev_model.sv and a short resend interval
`timescale 1ns/1ps
module tb;
    localparam int RESEND = 50;
    logic        ref_clk, nrst, base_frequency_select, m66en, reg_wr, reg_rd, bridge_req;
    logic        cfg_req, cfg_type1, pme_n, msg_ready, frame_n, irdy_n, cfg_local;
    logic        pci_cfg_valid, pci_cfg_type1, bridge_gnt, msg_valid;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, cfg_bus, sec_bus_num, msg_tag, v;
    logic [6:0]  secondary_clock_outputs, acc;
    logic [5:0]  req_n, gnt_n, want, respond, cfg_reg;
    logic [4:0]  cfg_dev;
    logic [3:0]  intx_n, lines;
    logic [2:0]  cfg_fn;
    logic [1:0]  msg_code;
    logic [15:0] msg_req_id;
    logic [31:0] pci_cfg_addr;
    pci_sec_pkg::msg_kind_t msg_kind;
    int          n_fail = 0;
    int          n_tests = 0;
    int          i, n, r;

    pci_sec_support #(.PME_RESEND_CYC(RESEND)) dut_u (.ref_clk, .nrst, .base_frequency_select, .m66en,
        .secondary_clock_outputs, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .req_n, .bridge_req,
        .frame_n, .irdy_n, .gnt_n, .bridge_gnt, .cfg_req, .cfg_type1, .cfg_bus, .cfg_dev, .cfg_fn, .cfg_reg,
        .sec_bus_num, .cfg_local, .pci_cfg_valid, .pci_cfg_type1, .pci_cfg_addr, .intx_n, .pme_n,
        .msg_ready, .msg_valid, .msg_kind, .msg_code, .msg_req_id, .msg_tag);
    pci_dev_model devs_u (.ref_clk, .want, .respond, .gnt_n, .req_n, .frame_n, .irdy_n);

    // clock generator
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // byte port: strobe held one edge, read data looked at after it lands
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk($sformatf("reg %h", a), e, reg_rdata);
        @(posedge ref_clk);
    endtask

    // expected address phase: one-hot select for devices 0 to 15 on the secondary bus, type 1 layout beyond it
    function automatic logic [31:0] exp_addr(logic [7:0] b, logic [4:0] d, logic [2:0] f, logic [5:0] g);
        if (b == sec_bus_num)
            return {(d[4] ? 16'h0000 : 16'h0001 << d), 5'h00, f, g, 2'b00};
        return {8'h00, b, d, f, g, 2'b01};
    endfunction

    task automatic cfg(input logic t1, input logic [7:0] b, input logic [4:0] d, input logic [2:0] f,
                       input logic [5:0] g);
        @(posedge ref_clk);
        cfg_req <= 1'b1;
        {cfg_type1, cfg_bus, cfg_dev, cfg_fn, cfg_reg} <= {t1, b, d, f, g};
        @(posedge ref_clk);
        cfg_req <= 1'b0;
        @(negedge ref_clk);
        chk("cfg_local", !t1, cfg_local);
        chk("pci_cfg_valid", t1, pci_cfg_valid);
        if (t1)
        begin
            chk("pci_cfg_type1", b != sec_bus_num, pci_cfg_type1);
            chk("pci_cfg_addr", exp_addr(b, d, f, g), pci_cfg_addr);
        end
        @(posedge ref_clk);
    endtask

    // waits for one upstream message, compares it, then accepts it with a ready pulse
    task automatic msg(input logic [1:0] k, input logic [1:0] c);
        int w;
        w = 0;
        do @(negedge ref_clk); while (msg_valid !== 1'b1 && ++w < RESEND + 30);
        chk("msg_kind", k, msg_kind);
        if (k == 2'b11)
        begin
            chk("msg_tag", 8'h00, msg_tag);
            chk("msg_req_id", {sec_bus_num, 8'h00}, msg_req_id);
        end
        else
            chk("msg_code", c, msg_code);
        @(posedge ref_clk);
        msg_ready <= 1'b1;
        @(posedge ref_clk);
        msg_ready <= 1'b0;
    endtask

    // length of one continuous grant to device d
    task automatic run_len(input int d, output int len);
        int w;
        len = 0;
        for (w = 0; w < 20 && gnt_n[d] !== 1'b0; w++) @(negedge ref_clk);
        while (gnt_n[d] === 1'b0 && len < 40)
        begin
            @(negedge ref_clk);
            len++;
        end
        @(posedge ref_clk);
    endtask

    // reference cycles per output period for strap pair s
    function automatic int per(int s);
        return (s == 3) ? pci_sec_pkg::PER66_CYC : (s == 2) ? pci_sec_pkg::PER33_CYC :
               (s == 1) ? pci_sec_pkg::PER50_CYC : pci_sec_pkg::PER25_CYC;
    endfunction

    // watchdog well beyond the expected run length
    initial
    begin
        #600000;
        n_fail++;
        wrap_up();
    end

    initial
    begin
        {nrst, reg_wr, reg_rd, bridge_req, cfg_req, cfg_type1, msg_ready, want, respond} = '0;
        {base_frequency_select, m66en, pme_n, intx_n} = '1;
        {reg_addr, reg_wdata, cfg_bus, cfg_dev, cfg_fn, cfg_reg} = '0;
        sec_bus_num = 8'h5A;
        void'($urandom(38324));
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset values, unmapped read, read-only status
        rdc(8'hD8, 8'h7F);
        rdc(8'hDC, 8'h40);
        rdc(8'hDD, 8'h00);
        wr(8'hDE, 8'hFF);
        rdc(8'hDE, 8'h00);
        rdc(8'h55, 8'h00);
        $display("registers done");
        // clock rate per strap pair, counted on the loopback output
        for (i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            base_frequency_select <= i[1];
            m66en <= i[0];
            repeat (20) @(negedge ref_clk);
            n = 0;
            v = {7'h00, secondary_clock_outputs[6]};
            repeat (200)
            begin
                @(negedge ref_clk);
                n += (!v[0] && secondary_clock_outputs[6] === 1'b1);
                v[0] = secondary_clock_outputs[6];
            end
            r = 200 / per(i);
            chk("clock rate", 1, n >= r - 1 && n <= r + 1);
        end
        // gating: all off, then only the loopback output
        for (i = 0; i < 2; i++)
        begin
            wr(8'hD8, i ? 8'h40 : 8'h00);
            repeat (4) @(negedge ref_clk);
            acc = 7'h00;
            repeat (40)
            begin
                @(negedge ref_clk);
                acc |= secondary_clock_outputs;
            end
            chk("clock gating", i ? 7'h40 : 7'h00, acc);
        end
        wr(8'hD8, 8'hFF);
        rdc(8'hD8, 8'h7F);
        $display("clocks done");
        // config translation: corner devices, then random requests
        cfg(1'b0, 8'h00, 5'h03, 3'h1, 6'h05);
        cfg(1'b1, sec_bus_num, 5'h10, 3'h7, 6'h3F);
        cfg(1'b1, sec_bus_num, 5'h0F, 3'h0, 6'h00);
        for (i = 0; i < 16; i++)
            cfg(1'($urandom), $urandom_range(1) ? sec_bus_num : 8'($urandom), 5'($urandom), 3'($urandom),
                6'($urandom));
        $display("config done");
        // interrupt edges: all four lines, then two random sets, asserted and released together
        for (r = 0; r < 3; r++)
        begin
            lines = r ? 4'($urandom) | 4'h2 : 4'hF;
            intx_n <= ~lines;
            for (i = 0; i < 4; i++)
                if (lines[i]) msg(2'b01, 2'(i));
            intx_n <= 4'hF;
            for (i = 0; i < 4; i++)
                if (lines[i]) msg(2'b10, 2'(i));
        end
        // power event: first message, one resend, then silence
        pme_n <= 1'b0;
        msg(2'b11, 2'b00);
        msg(2'b11, 2'b00);
        pme_n <= 1'b1;
        msg_ready <= 1'b1;
        repeat (4) @(posedge ref_clk);
        msg_ready <= 1'b0;
        n = 0;
        repeat (RESEND + 20)
        begin
            @(negedge ref_clk);
            n += (msg_valid !== 1'b0);
        end
        chk("pme stop", 0, n);
        $display("messages done");
        // silent device: timeout after 16 clocks, status bit, auto-mask and its removal
        wr(8'hDD, 8'h80);
        want <= 6'h04;
        run_len(2, n);
        chk("grant run", 16, n);
        want <= 6'h00;
        rdc(8'hDE, 8'h04);
        wr(8'hDD, 8'hC0);
        want <= 6'h04;
        run_len(2, n);
        run_len(2, r);
        chk("auto mask", 16, n + r);
        wr(8'hDD, 8'h80);
        run_len(2, n);
        chk("unmask", 1, n > 0);
        // masked request is never granted; status clears with reporting off
        wr(8'hDD, 8'h04);
        // a grant already running when the mask lands must drain first
        repeat (4) @(posedge ref_clk);
        run_len(2, n);
        chk("mask", 0, n);
        rdc(8'hDE, 8'h00);
        want <= 6'h00;
        // responding device loses the grant early and never times out
        wr(8'hDD, 8'h80);
        want <= 6'h10;
        respond <= 6'h10;
        run_len(4, n);
        chk("responder", 1, n > 0 && n < 16);
        want <= 6'h00;
        rdc(8'hDE, 8'h00);
        // tiers: bridge high by default, device 0 high after a tier change
        for (i = 0; i < 2; i++)
        begin
            wr(8'hDC, i ? 8'h01 : 8'h40);
            bridge_req <= 1'b1;
            want <= 6'h01;
            repeat (4) @(negedge ref_clk);
            chk("tier", i ? 7'h3E : 7'h7F, {bridge_gnt, gnt_n});
            @(posedge ref_clk);
            bridge_req <= 1'b0;
            want <= 6'h00;
            repeat (6) @(posedge ref_clk);
        end
        // parking on the bridge only when the park bit is set
        for (i = 0; i < 2; i++)
        begin
            wr(8'hDC, {i[0], 7'h40});
            repeat (6) @(negedge ref_clk);
            chk("park", i[0], bridge_gnt);
        end
        $display("arbiter done");
        wrap_up();
    end
endmodule
